// file: src/bcb_exec.sv
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module bcb_exec #(
    parameter int PC_W = 24
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic [PC_W-1:0] instr_pc,
    output logic instr_ready,
    input wire logic carry_flag,
    input wire logic negative_flag,
    input wire logic overflow_flag,
    output logic [PC_W-1:0] pc_out,
    output logic pc_load,
    output logic nop_inject,
    output logic [15:0] dmem_addr,
    output logic dmem_rd,
    output logic dmem_wr,
    output logic [15:0] dmem_wdata,
    input wire logic [15:0] dmem_rdata
);
    import bcb_pkg::*;

    if (PC_W < 18 || PC_W > 32) begin : g_bad_pc
        $error("bcb_exec: PC_W must be 18 to 32");
    end

    localparam logic [PC_W-1:0] PC_INC = PC_W'(PC_STEP);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] clr_bit(input logic [15:0] v,
                                            input logic [3:0] p);
        clr_bit = v & ~(16'h0001 << p);
    endfunction : clr_bit

    function automatic logic [PC_W-1:0] br_target(input logic [PC_W-1:0] pc,
                                                  input logic [15:0] off);
        logic [PC_W-1:0] ext;
        ext = {{(PC_W-17){off[15]}}, off, 1'b0};
        br_target = pc + PC_INC + ext;
    endfunction : br_target

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bcb_state_t state_q, state_d;
    logic [1:0] cnt_q, cnt_d;
    logic [PC_W-1:0] tgt_q, tgt_d, pc_q, pc_d;
    logic pc_load_q, pc_load_d, nop_q, nop_d, ready_q, ready_d;
    logic [15:0] wnew_q, wnew_d, addr_q, addr_d;
    logic byte_q, byte_d;
    logic [3:0] pos_q, pos_d, sreg_q, sreg_d, wsel_q, wsel_d;
    logic [2:0] mode_q, mode_d;
    logic [15:0] dm_addr_q, dm_addr_d, dm_wdata_q, dm_wdata_d;
    logic dm_rd_q, dm_rd_d, dm_wr_q, dm_wr_d;
    logic ext_q, ext_d, taken_q, taken_d, illegal_q, illegal_d;
    logic [15:0] wview_q, wview_d;
    logic wpend_q, wpend_d;
    logic [31:0] rdata_q, rdata_d;

    logic m_re, m_we;
    logic [3:0] m_addr;
    logic [15:0] m_wdata, m_rdata;
    logic in_win, w_bus, accept, busy;
    logic [7:0] opc;
    logic [1:0] extra;
    logic [15:0] step, opnd_val;
    logic [3:0] pos_eff;

    bcb_wfile #(
        .DW(16),
        .AW(4)
    ) u_wfile (
        .clk(clk),
        .rst(rst),
        .re(m_re),
        .we(m_we),
        .addr(m_addr),
        .wdata(m_wdata),
        .rdata_q(m_rdata)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        tgt_d = tgt_q;
        pc_d = pc_q;
        pc_load_d = 1'b0;
        nop_d = nop_q;
        wnew_d = wnew_q;
        addr_d = addr_q;
        byte_d = byte_q;
        pos_d = pos_q;
        sreg_d = sreg_q;
        mode_d = mode_q;
        dm_addr_d = dm_addr_q;
        dm_wdata_d = dm_wdata_q;
        dm_rd_d = 1'b0;
        dm_wr_d = 1'b0;
        ext_d = ext_q;
        taken_d = taken_q;
        illegal_d = illegal_q;
        wsel_d = wsel_q;
        wview_d = wview_q;
        wpend_d = 1'b0;
        rdata_d = 32'h0000_0000;
        m_re = 1'b0;
        m_we = 1'b0;
        m_addr = sreg_q;
        m_wdata = 16'h0000;
        busy = (state_q != S_IDLE);
        in_win = (bus_addr[7:6] == REG_WBASE[7:6]);
        w_bus = !busy && bus_wr && (in_win || bus_addr == REG_WSEL);
        accept = instr_valid && ready_q && !w_bus;
        opc = instr_word[F_OPC_HI:F_OPC_LO];
        extra = ext_q ? 2'(BR_CYC_EXT - 1) : 2'(BR_CYC_BASIC - 1);
        opnd_val = m_rdata;
        step = byte_q ? STEP_BYTE : STEP_WORD;
        pos_eff = byte_q ? {1'b0, pos_q[2:0]} : pos_q;

        // Register writes
        if (bus_wr) begin
            case (bus_addr)
                REG_CTRL: ext_d = bus_wdata[CTRL_EXT];
                REG_STAT: begin
                    if (bus_wdata[ST_ILLEGAL]) begin
                        illegal_d = 1'b0;
                    end
                end
                REG_WSEL: begin
                    wsel_d = bus_wdata[3:0];
                    if (!busy) begin
                        m_re = 1'b1;
                        m_addr = bus_wdata[3:0];
                        wpend_d = 1'b1;
                    end
                end
                default: begin
                    if (in_win && !busy) begin
                        m_we = 1'b1;
                        m_addr = bus_addr[5:2];
                        m_wdata = bus_wdata[15:0];
                    end
                end
            endcase
        end
        if (wpend_q) begin
            wview_d = m_rdata;
        end

        // Register reads
        if (bus_rd) begin
            case (bus_addr)
                REG_CTRL: rdata_d[CTRL_EXT] = ext_q;
                REG_STAT: begin
                    rdata_d[ST_BUSY] = busy;
                    rdata_d[ST_TAKEN] = taken_q;
                    rdata_d[ST_ILLEGAL] = illegal_q;
                end
                REG_TGT: rdata_d[PC_W-1:0] = pc_q;
                REG_WSEL: rdata_d[3:0] = wsel_q;
                REG_WVIEW: rdata_d[15:0] = wview_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end

        // Execution
        case (state_q)
            S_IDLE: begin
                if (accept) begin
                    sreg_d = instr_word[F_REG_HI:F_REG_LO];
                    pos_d = instr_word[F_POS_HI:F_POS_LO];
                    byte_d = instr_word[F_BYTE];
                    mode_d = instr_word[F_MODE_HI:F_MODE_LO];
                    tgt_d = br_target(instr_pc,
                                      instr_word[F_OFF_HI:0]);
                    cnt_d = extra - 2'd1;
                    if (opc == OP_BIT_CLEAR) begin
                        if ((instr_word[11:0] & BC_FIXED_MASK) == 12'h000
                            && instr_word[F_MODE_HI:F_MODE_LO]
                               <= MD_PREDEC) begin
                            m_re = 1'b1;
                            m_addr = instr_word[F_REG_HI:F_REG_LO];
                            state_d = S_BC_OP;
                        end else begin
                            illegal_d = 1'b1;
                        end
                    end else if (opc == OP_REL_ALWAYS) begin
                        taken_d = 1'b1;
                        nop_d = 1'b1;
                        state_d = S_FLUSH;
                    end else if (opc == OP_REL_CARRY) begin
                        taken_d = carry_flag;
                        nop_d = carry_flag;
                        state_d = carry_flag ? S_FLUSH : S_IDLE;
                    end else if (opc == OP_REL_SGE) begin
                        taken_d = (negative_flag == overflow_flag);
                        nop_d = taken_d;
                        state_d = taken_d ? S_FLUSH : S_IDLE;
                    end else if (instr_word[23:4] ==
                                 (ext_q ? OP_CB_EXT : OP_CB_BASIC)) begin
                        taken_d = 1'b1;
                        tgt_d = instr_pc;
                        nop_d = 1'b1;
                        m_re = 1'b1;
                        m_addr = instr_word[F_REG_HI:F_REG_LO];
                        state_d = S_BR_RD;
                    end
                end
            end
            S_FLUSH: begin
                if (cnt_q == 2'd0) begin
                    nop_d = 1'b0;
                    pc_load_d = 1'b1;
                    pc_d = tgt_q;
                    state_d = S_IDLE;
                end else begin
                    cnt_d = cnt_q - 2'd1;
                end
            end
            S_BR_RD: begin
                tgt_d = br_target(tgt_q, opnd_val);
                if (extra == 2'd1) begin
                    nop_d = 1'b0;
                    pc_load_d = 1'b1;
                    pc_d = tgt_d;
                    state_d = S_IDLE;
                end else begin
                    cnt_d = extra - 2'd2;
                    state_d = S_FLUSH;
                end
            end
            S_BC_OP: begin
                if (mode_q == MD_DIRECT) begin
                    m_we = 1'b1;
                    m_addr = sreg_q;
                    m_wdata = clr_bit(opnd_val, pos_eff);
                    state_d = S_IDLE;
                end else begin
                    case (mode_q)
                        MD_POSTINC: wnew_d = opnd_val + step;
                        MD_POSTDEC: wnew_d = opnd_val - step;
                        MD_PREINC: wnew_d = opnd_val + step;
                        MD_PREDEC: wnew_d = opnd_val - step;
                        default: wnew_d = opnd_val;
                    endcase
                    addr_d = (mode_q >= MD_PREINC) ? wnew_d : opnd_val;
                    dm_addr_d = addr_d;
                    dm_rd_d = 1'b1;
                    state_d = S_BC_MWAIT;
                end
            end
            S_BC_MWAIT: state_d = S_BC_MWR;
            S_BC_MWR: begin
                dm_wdata_d = clr_bit(dmem_rdata, byte_q ?
                    {addr_q[0], pos_q[2:0]} : pos_q);
                dm_wr_d = 1'b1;
                m_we = 1'b1;
                m_addr = sreg_q;
                m_wdata = wnew_q;
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
        ready_d = (state_d == S_IDLE);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            cnt_q <= 2'd0;
            tgt_q <= '0;
            pc_q <= '0;
            pc_load_q <= 1'b0;
            nop_q <= 1'b0;
            ready_q <= 1'b1;
            wnew_q <= 16'h0000;
            addr_q <= 16'h0000;
            byte_q <= 1'b0;
            pos_q <= 4'h0;
            sreg_q <= 4'h0;
            mode_q <= MD_DIRECT;
            dm_addr_q <= 16'h0000;
            dm_wdata_q <= 16'h0000;
            dm_rd_q <= 1'b0;
            dm_wr_q <= 1'b0;
            ext_q <= CTRL_EXT_RST;
            taken_q <= 1'b0;
            illegal_q <= 1'b0;
            wsel_q <= 4'h0;
            wview_q <= 16'h0000;
            wpend_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            tgt_q <= tgt_d;
            pc_q <= pc_d;
            pc_load_q <= pc_load_d;
            nop_q <= nop_d;
            ready_q <= ready_d;
            wnew_q <= wnew_d;
            addr_q <= addr_d;
            byte_q <= byte_d;
            pos_q <= pos_d;
            sreg_q <= sreg_d;
            mode_q <= mode_d;
            dm_addr_q <= dm_addr_d;
            dm_wdata_q <= dm_wdata_d;
            dm_rd_q <= dm_rd_d;
            dm_wr_q <= dm_wr_d;
            ext_q <= ext_d;
            taken_q <= taken_d;
            illegal_q <= illegal_d;
            wsel_q <= wsel_d;
            wview_q <= wview_d;
            wpend_q <= wpend_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata = rdata_q;
    assign instr_ready = ready_q;
    assign pc_out = pc_q;
    assign pc_load = pc_load_q;
    assign nop_inject = nop_q;
    assign dmem_addr = dm_addr_q;
    assign dmem_rd = dm_rd_q;
    assign dmem_wr = dm_wr_q;
    assign dmem_wdata = dm_wdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_clr_direct: assert property (
        state_q == S_BC_OP && mode_q == MD_DIRECT
        |-> m_we && (m_wdata ^ m_rdata) == (m_rdata & (16'h0001 << pos_eff)))
        else $error("direct bit clear wrong");
    a_clr_mem_one: assert property (
        dm_wr_q
        |-> $countones(dm_wdata_q ^ $past(dmem_rdata)) <= 1
            && (dm_wdata_q & ~$past(dmem_rdata)) == 16'h0000)
        else $error("memory bit clear touched other bits");
    a_byte_pos: assert property (
        state_q == S_BC_MWR && byte_q
        |=> dm_wdata_q[15 - 8 * addr_q[0] -: 8] ==
            $past(dmem_rdata[15 - 8 * addr_q[0] -: 8]))
        else $error("byte clear left its byte");
    a_step_size: assert property (
        state_q == S_BC_OP && mode_q == MD_POSTINC
        |=> wnew_q == $past(m_rdata) + (byte_q ? 16'h0001 : 16'h0002)
            && dm_addr_q == $past(m_rdata))
        else $error("post increment wrong");
    a_rel_target: assert property (
        accept && opc == OP_REL_ALWAYS
        |=> tgt_q == $past(instr_pc) + PC_INC
            + {{(PC_W-17){$past(instr_word[15])}}, $past(instr_word[15:0]),
               1'b0})
        else $error("relative target wrong");
    a_rel_basic: assert property (
        accept && opc == OP_REL_ALWAYS && !ext_q
        |=> nop_q && !ready_q ##1 !nop_q && pc_load_q && ready_q)
        else $error("basic branch length wrong");
    a_rel_ext: assert property (
        accept && opc == OP_REL_ALWAYS && ext_q
        |=> nop_q [*3] ##1 !nop_q && pc_load_q && pc_q == $past(tgt_q))
        else $error("extended branch length wrong");
    a_carry_cond: assert property (
        accept && opc == OP_REL_CARRY
        |=> nop_q == $past(carry_flag) && ready_q == !$past(carry_flag))
        else $error("carry branch condition wrong");
    a_sge_cond: assert property (
        accept && opc == OP_REL_SGE
        |=> nop_q == ($past(negative_flag) == $past(overflow_flag)))
        else $error("signed ge condition wrong");
    a_cb_target: assert property (
        state_q == S_BR_RD
        |=> tgt_q == $past(tgt_q) + PC_INC
            + {{(PC_W-17){$past(m_rdata[15])}}, $past(m_rdata), 1'b0})
        else $error("computed target wrong");
    a_load_after_nop: assert property ($fell(nop_q) |-> pc_load_q)
        else $error("pc not loaded after nop");
endmodule : bcb_exec
`default_nettype wire

// file: src/bcb_pkg.sv
// What this block does
// - Bit clear zeroes only the chosen operand bit; no status flag changes.
// - Bit positions count from bit 0; up to 7 for bytes, 15 for words.
// - Byte-select bit: zero means word operation, one means byte operation.
// - Encoding holds 4-bit position, 3-bit mode and register in low nibble.
// - Operand is the register or memory through it, with pre/post inc/dec.
// - Branch offset is a 16-bit signed word count, -32768 to +32767.
// - Taken branch loads PC with instruction address plus two plus 2*offset.
// - Taken conditional branch adds cycles with a NOP injected in place.
// - Carry branch, same as unsigned greater-or-equal, taken when carry is 1.
// - Signed greater-or-equal branch taken when negative equals overflow.
// - Computed branch adds sign-extended 2*register to PC plus two, always.
// - Computed branch names register in low nibble; two variant patterns.
package bcb_pkg;

    // ------------------------------------------------------------
    // Opcodes and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OP_BIT_CLEAR = 8'hA1;
    localparam logic [7:0] OP_REL_ALWAYS = 8'h37;
    localparam logic [7:0] OP_REL_CARRY = 8'h31;
    localparam logic [7:0] OP_REL_SGE = 8'h3D;
    localparam logic [19:0] OP_CB_BASIC = 20'h01600;
    localparam logic [19:0] OP_CB_EXT = 20'h01060;
    localparam int F_OPC_HI = 23;
    localparam int F_OPC_LO = 16;
    localparam int F_POS_HI = 15;
    localparam int F_POS_LO = 12;
    localparam int F_BYTE = 10;
    localparam int F_MODE_HI = 6;
    localparam int F_MODE_LO = 4;
    localparam int F_REG_HI = 3;
    localparam int F_REG_LO = 0;
    localparam int F_OFF_HI = 15;
    localparam logic [11:0] BC_FIXED_MASK = 12'hB80;

    // ------------------------------------------------------------
    // Addressing modes
    // ------------------------------------------------------------
    localparam logic [2:0] MD_DIRECT = 3'h0;
    localparam logic [2:0] MD_IND = 3'h1;
    localparam logic [2:0] MD_POSTINC = 3'h2;
    localparam logic [2:0] MD_POSTDEC = 3'h3;
    localparam logic [2:0] MD_PREINC = 3'h4;
    localparam logic [2:0] MD_PREDEC = 3'h5;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int BR_CYC_BASIC = 2;
    localparam int BR_CYC_EXT = 4;
    localparam int PC_STEP = 2;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_TGT = 8'h08;
    localparam logic [7:0] REG_WSEL = 8'h0C;
    localparam logic [7:0] REG_WVIEW = 8'h10;
    localparam logic [7:0] REG_WBASE = 8'h40;
    localparam int CTRL_EXT = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_TAKEN = 1;
    localparam int ST_ILLEGAL = 2;
    localparam logic CTRL_EXT_RST = 1'b0;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_BC_OP = 3'b001,
        S_BC_MWAIT = 3'b010,
        S_BC_MWR = 3'b011,
        S_BR_RD = 3'b100,
        S_FLUSH = 3'b101
    } bcb_state_t;

endpackage : bcb_pkg

// file: src/bcb_wfile.sv
`timescale 1ns/10ps
`default_nettype none
module bcb_wfile #(
    parameter int DW = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic re,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata_q
);
    // ------------------------------------------------------------
    // Working register array, registered read
    // ------------------------------------------------------------
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    if (DW < 1 || AW < 1) begin : g_bad_size
        $error("bcb_wfile: bad size");
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < (1 << AW); i++) begin
                mem_q[i] <= '0;
            end
            rdata_q <= '0;
        end else begin
            if (we) begin
                mem_q[addr] <= wdata;
            end
            if (re) begin
                rdata_q <= mem_q[addr];
            end
        end
    end
endmodule : bcb_wfile
`default_nettype wire

// file: verification/tb_bcb_exec.sv
`timescale 1ns/10ps
`default_nettype none
module tb_bcb_exec;
import bcb_pkg::*;
logic clk, rst, bus_wr, bus_rd, instr_valid, instr_ready, pc_load;
logic carry_flag, negative_flag, overflow_flag, nop_inject, dmem_rd, dmem_wr;
logic rd_seen = 1'b0;
logic [7:0] bus_addr;
logic [31:0] bus_wdata, bus_rdata;
logic [23:0] instr_word, instr_pc, pc_out;
logic [15:0] dmem_addr, dmem_wdata, mem_val;
logic [15:0] dmem_rdata = 16'h0000;
int miscompares = 0;
int checks_done = 0;
int nops = 0;
logic [31:0] busq[$];
logic [31:0] memq[$];
logic [31:0] pcq[$];
int nopq[$];

bcb_exec #(.PC_W(24)) uut (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .instr_ready(instr_ready),
    .carry_flag(carry_flag), .negative_flag(negative_flag),
    .overflow_flag(overflow_flag), .pc_out(pc_out), .pc_load(pc_load),
    .nop_inject(nop_inject), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
end

// ------------------------------------------------------------
// Result checking
// ------------------------------------------------------------
task automatic report(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        miscompares++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
endtask : report

task automatic chk_bus;
    report(bus_rdata, busq.size() > 0 ? busq.pop_front() : ~bus_rdata);
endtask : chk_bus

task automatic chk_pc;
    report({8'h00, pc_out}, pcq.size() > 0 ? pcq.pop_front() : ~pc_out);
    report(nops, nopq.size() > 0 ? nopq.pop_front() : -1);
    nops = 0;
endtask : chk_pc

task automatic chk_mem;
    report({dmem_addr, dmem_wdata},
        memq.size() > 0 ? memq.pop_front() : ~{dmem_addr, dmem_wdata});
endtask : chk_mem

always @(posedge clk) rd_seen <= bus_rd;

always @(negedge clk) begin
    if (!rst) begin
        if (rd_seen) chk_bus();
        if (nop_inject === 1'b1) nops++;
        if (pc_load === 1'b1) chk_pc();
        if (dmem_wr === 1'b1) chk_mem();
    end
end

// Data memory answers one cycle after a read, junk otherwise
always @(posedge clk) dmem_rdata <= dmem_rd ? mem_val : ~dmem_rdata;

// ------------------------------------------------------------
// Drivers
// ------------------------------------------------------------
task automatic bwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
endtask : bwr

task automatic brd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    busq.push_back(e);
    @(posedge clk);
    bus_rd <= 1'b0;
endtask : brd

task automatic wread(input logic [3:0] n, input logic [15:0] e);
    bwr(REG_WSEL, {28'h0000000, n});
    brd(REG_WVIEW, {16'h0000, e});
endtask : wread

task automatic issue(input logic [23:0] w, input logic [23:0] pc,
    input logic [2:0] f);
    int i;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_pc <= pc;
    {carry_flag, negative_flag, overflow_flag} <= f;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    for (i = 0; i < 20 && instr_ready !== 1'b1; i++) @(negedge clk);
    if (i == 20) miscompares++;
endtask : issue

task automatic jmp(input logic [23:0] w, input logic [15:0] off,
    input logic [23:0] pc, input logic [2:0] f, input bit tk, input int e);
    if (tk) begin
        pcq.push_back({8'h00, pc + 24'h000002 + {{7{off[15]}}, off, 1'b0}});
        nopq.push_back(e);
    end
    issue(w, pc, f);
endtask : jmp

function automatic logic [23:0] bc(input logic [3:0] p, input logic b,
    input logic [2:0] m, input logic [3:0] r);
    return {OP_BIT_CLEAR, p, 1'b0, b, 3'b000, m, r};
endfunction : bc

task automatic summarize;
    if (busq.size() + pcq.size() + memq.size() != 0) miscompares++;
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask : summarize

initial begin
    #(40 * 20000);
    miscompares++;
    summarize();
end

initial begin
    int k;
    logic [15:0] v, a, ea;
    logic [3:0] r, p;
    logic b;
    logic [2:0] f;
    rst = 1'b1;
    {bus_wr, bus_rd, instr_valid, carry_flag} = 4'h0;
    {negative_flag, overflow_flag} = 2'b00;
    bus_addr = 8'h00;
    bus_wdata = 32'h00000000;
    instr_word = 24'h000000;
    instr_pc = 24'h000000;
    mem_val = 16'h0000;
    void'($urandom(32'hB190));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    report({31'h00000000, instr_ready}, 32'h00000001);
    bwr(8'h4C, 32'h00001234);
    wread(4'h3, 16'h1234);
    brd(8'h40, 32'h00000000);
    brd(8'h20, 32'h00000000);
    brd(REG_CTRL, 32'h00000000);
    for (k = 0; k < 8; k++) begin
        r = 4'($urandom);
        b = 1'($urandom);
        p = b ? {1'b0, 3'($urandom)} : 4'($urandom);
        v = 16'($urandom);
        bwr(REG_WBASE + {2'b00, r, 2'b00}, {16'h0000, v});
        issue(bc(p, b, MD_DIRECT, r), 24'h000000, 3'($urandom));
        wread(r, v & ~(16'h0001 << p));
    end
    a = 16'h1000;
    bwr(8'h50, {16'h0000, a});
    for (k = 1; k <= 5; k++) begin
        mem_val = 16'($urandom);
        p = 4'($urandom);
        ea = (k == 4) ? a + 16'h0002 : (k == 5) ? a - 16'h0002 : a;
        memq.push_back({ea, mem_val & ~(16'h0001 << p)});
        issue(bc(p, 1'b0, 3'(k), 4'h4), 24'h000000, 3'($urandom));
        if (k == 2 || k == 4) a = a + 16'h0002;
        if (k == 3 || k == 5) a = a - 16'h0002;
    end
    wread(4'h4, a);
    bwr(8'h54, 32'h00000801);
    mem_val = 16'hFFFF;
    memq.push_back(32'h0801F7FF);
    issue(bc(4'h3, 1'b1, MD_POSTINC, 4'h5), 24'h000000, 3'b000);
    wread(4'h5, 16'h0802);
    jmp({OP_REL_CARRY, 16'h0004}, 16'h0004, 24'h002000, 3'b000, 0, 0);
    for (k = 0; k < 2; k++) begin
        issue(k ? bc(4'h0, 1'b0, 3'h6, 4'h0) : 24'hA10800, 24'h000000, 3'b000);
        brd(REG_STAT, 32'h00000004);
        bwr(REG_STAT, 32'h00000004);
        brd(REG_STAT, 32'h00000000);
    end
    jmp({OP_REL_ALWAYS, 16'h0004}, 16'h0004, 24'h002000, 3'b000, 1, 1);
    brd(REG_TGT, 32'h0000200A);
    brd(REG_STAT, 32'h00000002);
    jmp({OP_REL_ALWAYS, 16'h8000}, 16'h8000, 24'h020000, 3'b111, 1, 1);
    jmp({OP_REL_ALWAYS, 16'h7FFF}, 16'h7FFF, 24'h000000, 3'b010, 1, 1);
    for (k = 0; k < 8; k++) begin
        f = 3'(k);
        jmp({OP_REL_CARRY, 16'hFFF0}, 16'hFFF0, 24'h003000, f, f[2], 1);
        jmp({OP_REL_SGE, 16'h0020}, 16'h0020, 24'h004000, f,
            f[1] == f[0], 1);
    end
    bwr(8'h5C, 32'h00000084);
    bwr(8'h60, 32'h0000FFFE);
    jmp({OP_CB_BASIC, 4'h7}, 16'h0084, 24'h002000, 3'b000, 1, 1);
    jmp({OP_CB_BASIC, 4'h8}, 16'hFFFE, 24'h002000, 3'b101, 1, 1);
    bwr(REG_CTRL, 32'h00000001);
    brd(REG_CTRL, 32'h00000001);
    jmp({OP_REL_ALWAYS, 16'h0004}, 16'h0004, 24'h002000, 3'b000, 1, 3);
    jmp({OP_REL_CARRY, 16'h0002}, 16'h0002, 24'h002000, 3'b100, 1, 3);
    jmp({OP_CB_EXT, 4'h7}, 16'h0084, 24'h002000, 3'b000, 1, 3);
    jmp({OP_CB_BASIC, 4'h7}, 16'h0084, 24'h002000, 3'b000, 0, 0);
    repeat (4) @(posedge clk);
    summarize();
end
endmodule : tb_bcb_exec
`default_nettype wire
